//--- hdl/cdfs_map.svh
`ifndef CDFS_MAP_SVH
`define CDFS_MAP_SVH

// Word index on the Avalon address bus; byte address is four times this
`define CDFS_IDX_CTRL       4'h0
`define CDFS_IDX_START_HI   4'h1
`define CDFS_IDX_START_LO   4'h2
`define CDFS_IDX_WBUF_HI    4'h3
`define CDFS_IDX_WBUF_LO    4'h4
`define CDFS_IDX_END_HI     4'h5
`define CDFS_IDX_END_LO     4'h6
`define CDFS_IDX_MODE       4'h7
`define CDFS_IDX_STATUS     4'h8

// Sequencer control fields
`define CDFS_CTRL_START     7
`define CDFS_CTRL_SEL       3
`define CDFS_CTRL_CMD_HI    2
`define CDFS_CTRL_RESET     8'h00

// Reset values and writable masks of the pointer and buffer registers
`define CDFS_REG16_RESET    16'h0000
`define CDFS_HI_MASK        16'h000F
`define CDFS_FULL_MASK      16'hFFFF

// Mode register: bit 0 set selects data flash programming mode
`define CDFS_MODE_DATA      0

// Status register fields
`define CDFS_ST_BUSY        0
`define CDFS_ST_DONE        1
`define CDFS_ST_FAIL        2
`define CDFS_ST_ILLEGAL     3

// Address steps for range commands, bytes
`define CDFS_STEP_BLOCK     21'h000400
`define CDFS_STEP_WORD      21'h000004
`define CDFS_STEP_BYTE      21'h000001
`define CDFS_BLOCK_MASK     20'hFFC00

// Byte lanes for one code flash word and one data flash byte
`define CDFS_BE_WORD        4'hF
`define CDFS_BE_BYTE        4'h1

`endif

//--- hdl/cdfs_pkg.sv
package cdfs_pkg;

    typedef enum logic [2:0] {
        CDFS_CMD_NONE   = 3'h0,
        CDFS_CMD_WRITE  = 3'h1,
        CDFS_CMD_VERIFY = 3'h2,
        CDFS_CMD_BLANK  = 3'h3,
        CDFS_CMD_ERASE  = 3'h4
    } cdfs_cmd_e;

    typedef enum logic [1:0] {
        CDFS_ST_IDLE  = 2'h0,
        CDFS_ST_ISSUE = 2'h1,
        CDFS_ST_WAIT  = 2'h2
    } cdfs_state_e;

endpackage

//--- hdl/cdfs_wr_if.sv
`timescale 1ns/1ps
`default_nettype none

interface cdfs_wr_if;
    logic [31:0] data;
    logic [3:0]  be;

    modport src  (output data, be);
    modport sink (input  data, be);
endinterface

`default_nettype wire

//--- hdl/cdfs_reg16.sv
`timescale 1ns/1ps
`default_nettype none
`include "cdfs_map.svh"

module cdfs_reg16
    import cdfs_pkg::*;
#(
    parameter logic [15:0] RST  = `CDFS_REG16_RESET,
    parameter logic [15:0] MASK = `CDFS_FULL_MASK
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Write port
    input  wire logic        load,
    cdfs_wr_if.sink          wr,
    // Stored value
    output logic      [15:0] q
);

    logic [15:0] merged;

    always_comb begin
        merged[15:8] = wr.be[1] ? wr.data[15:8] : q[15:8];
        merged[7:0]  = wr.be[0] ? wr.data[7:0]  : q[7:0];
    end

    // Masked bits are read-only zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q <= RST;
        end else if (load) begin
            q <= merged & MASK;
        end
    end

endmodule

`default_nettype wire

//--- hdl/cdfs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "cdfs_map.svh"

module cdfs_sequencer
    import cdfs_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Avalon-MM register slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Flash macro operation port
    output logic             flashReq,
    output logic      [2:0]  flashOp,
    output logic             flashDataArea,
    output logic      [19:0] flashAddr,
    output logic      [31:0] flashWdata,
    output logic      [3:0]  flashByteEn,
    input  wire logic        flashAck,
    input  wire logic        flashFail
);

    cdfs_wr_if wr ();

    logic        busRequest;
    logic        accept;
    logic        wrAccept;
    logic        wrLow;
    logic [31:0] readMux;

    logic        startQ;
    logic        selQ;
    logic [2:0]  cmdQ;
    logic        launchQ;
    logic        modeDataQ;
    logic        doneQ;
    logic        failQ;
    logic        illegalQ;
    logic        failAccQ;

    logic [15:0] startHiQ;
    logic [15:0] startLoQ;
    logic [15:0] endHiQ;
    logic [15:0] endLoQ;
    logic [15:0] wbufHiQ;
    logic [15:0] wbufLoQ;

    logic [19:0] startAddr;
    logic [19:0] endAddr;
    logic [31:0] wbuf;

    cdfs_state_e stateQ;
    logic [19:0] curAddrQ;
    logic [20:0] nextAddr;
    logic [20:0] step;
    logic        legal;
    logic        isWrite;
    logic        lastUnit;
    logic        finish;
    logic        badLaunch;

    assign busRequest = avs_read | avs_write;
    assign accept     = busRequest & ~avs_waitrequest;
    assign wrAccept   = accept & avs_write;
    assign wrLow      = wrAccept & avs_byteenable[0];

    assign wr.data = avs_writedata;
    assign wr.be   = avs_byteenable;

    assign startAddr = {startHiQ[3:0], startLoQ};
    assign endAddr   = {endHiQ[3:0], endLoQ};
    assign wbuf      = {wbufHiQ, wbufLoQ};

    // Bus handshake: one wait cycle, then a single cycle with waitrequest low
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            avs_waitrequest <= 1'b1;
        end else if (busRequest && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    always_comb begin
        readMux = 32'h0000_0000;
        case (avs_address)
            `CDFS_IDX_CTRL: begin
                readMux[`CDFS_CTRL_START]  = startQ;
                readMux[`CDFS_CTRL_SEL]    = selQ;
                readMux[`CDFS_CTRL_CMD_HI:0] = cmdQ;
            end
            `CDFS_IDX_START_HI: readMux[15:0] = startHiQ;
            `CDFS_IDX_START_LO: readMux[15:0] = startLoQ;
            `CDFS_IDX_WBUF_HI:  readMux[15:0] = wbufHiQ;
            `CDFS_IDX_WBUF_LO:  readMux[15:0] = wbufLoQ;
            `CDFS_IDX_END_HI:   readMux[15:0] = endHiQ;
            `CDFS_IDX_END_LO:   readMux[15:0] = endLoQ;
            `CDFS_IDX_MODE:     readMux[`CDFS_MODE_DATA] = modeDataQ;
            `CDFS_IDX_STATUS: begin
                readMux[`CDFS_ST_BUSY]    = startQ;
                readMux[`CDFS_ST_DONE]    = doneQ;
                readMux[`CDFS_ST_FAIL]    = failQ;
                readMux[`CDFS_ST_ILLEGAL] = illegalQ;
            end
            default: readMux = 32'h0000_0000;
        endcase
    end

    // Read data is captured in the wait cycle and stands while waitrequest is low
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= readMux;
        end
    end

    // Pointer and buffer registers; frozen while a command runs
    cdfs_reg16 #(.RST(`CDFS_REG16_RESET), .MASK(`CDFS_HI_MASK)) uStartHi (
        .clk  (clk),
        .rstn (rstn),
        .load (wrAccept && !startQ && avs_address == `CDFS_IDX_START_HI),
        .wr   (wr),
        .q    (startHiQ)
    );

    cdfs_reg16 #(.RST(`CDFS_REG16_RESET), .MASK(`CDFS_FULL_MASK)) uStartLo (
        .clk  (clk),
        .rstn (rstn),
        .load (wrAccept && !startQ && avs_address == `CDFS_IDX_START_LO),
        .wr   (wr),
        .q    (startLoQ)
    );

    cdfs_reg16 #(.RST(`CDFS_REG16_RESET), .MASK(`CDFS_HI_MASK)) uEndHi (
        .clk  (clk),
        .rstn (rstn),
        .load (wrAccept && !startQ && avs_address == `CDFS_IDX_END_HI),
        .wr   (wr),
        .q    (endHiQ)
    );

    cdfs_reg16 #(.RST(`CDFS_REG16_RESET), .MASK(`CDFS_FULL_MASK)) uEndLo (
        .clk  (clk),
        .rstn (rstn),
        .load (wrAccept && !startQ && avs_address == `CDFS_IDX_END_LO),
        .wr   (wr),
        .q    (endLoQ)
    );

    cdfs_reg16 #(.RST(`CDFS_REG16_RESET), .MASK(`CDFS_FULL_MASK)) uWbufHi (
        .clk  (clk),
        .rstn (rstn),
        .load (wrAccept && !startQ && avs_address == `CDFS_IDX_WBUF_HI),
        .wr   (wr),
        .q    (wbufHiQ)
    );

    cdfs_reg16 #(.RST(`CDFS_REG16_RESET), .MASK(`CDFS_FULL_MASK)) uWbufLo (
        .clk  (clk),
        .rstn (rstn),
        .load (wrAccept && !startQ && avs_address == `CDFS_IDX_WBUF_LO),
        .wr   (wr),
        .q    (wbufLoQ)
    );

    // Control fields; ignored while a command runs
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            selQ <= 1'b0;
            cmdQ <= 3'h0;
        end else if (wrLow && !startQ && avs_address == `CDFS_IDX_CTRL) begin
            selQ <= avs_writedata[`CDFS_CTRL_SEL];
            cmdQ <= avs_writedata[`CDFS_CTRL_CMD_HI:0];
        end
    end

    // Start bit doubles as busy and drops when the command ends
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            startQ <= 1'b0;
        end else if (finish) begin
            startQ <= 1'b0;
        end else if (wrLow && !startQ && avs_address == `CDFS_IDX_CTRL) begin
            startQ <= avs_writedata[`CDFS_CTRL_START];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            launchQ <= 1'b0;
        end else begin
            launchQ <= wrLow && !startQ && avs_address == `CDFS_IDX_CTRL
                       && avs_writedata[`CDFS_CTRL_START];
        end
    end

    // Programming mode chooses code or data flash for write and erase
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            modeDataQ <= 1'b0;
        end else if (wrLow && !startQ && avs_address == `CDFS_IDX_MODE) begin
            modeDataQ <= avs_writedata[`CDFS_MODE_DATA];
        end
    end

    // Command decode
    always_comb begin
        legal   = 1'b0;
        isWrite = 1'b0;
        case (cmdQ)
            CDFS_CMD_WRITE: begin
                legal   = 1'b1;
                isWrite = 1'b1;
            end
            CDFS_CMD_VERIFY: legal = 1'b1;
            CDFS_CMD_BLANK:  legal = 1'b1;
            CDFS_CMD_ERASE:  legal = 1'b1;
            default:         legal = 1'b0;
        endcase
    end

    // Unit size: 1 KB blocks for erase, a word in code flash, a byte in data flash
    always_comb begin
        if (cmdQ == CDFS_CMD_ERASE) begin
            step = `CDFS_STEP_BLOCK;
        end else if (modeDataQ || selQ) begin
            step = `CDFS_STEP_BYTE;
        end else begin
            step = `CDFS_STEP_WORD;
        end
    end

    assign nextAddr  = {1'b0, curAddrQ} + step;
    assign lastUnit  = isWrite || nextAddr > {1'b0, endAddr};
    assign badLaunch = stateQ == CDFS_ST_IDLE && launchQ && !legal;
    assign finish    = badLaunch || (stateQ == CDFS_ST_WAIT && flashAck && lastUnit);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stateQ   <= CDFS_ST_IDLE;
            curAddrQ <= 20'h0_0000;
        end else begin
            case (stateQ)
                CDFS_ST_IDLE: begin
                    if (launchQ && legal) begin
                        stateQ <= CDFS_ST_ISSUE;
                        if (cmdQ == CDFS_CMD_ERASE) begin
                            curAddrQ <= startAddr & `CDFS_BLOCK_MASK;
                        end else begin
                            curAddrQ <= startAddr;
                        end
                    end
                end
                CDFS_ST_ISSUE: stateQ <= CDFS_ST_WAIT;
                CDFS_ST_WAIT: begin
                    if (flashAck) begin
                        if (lastUnit) begin
                            stateQ <= CDFS_ST_IDLE;
                        end else begin
                            stateQ   <= CDFS_ST_ISSUE;
                            curAddrQ <= nextAddr[19:0];
                        end
                    end
                end
                default: stateQ <= CDFS_ST_IDLE;
            endcase
        end
    end

    // One request pulse per unit toward the flash macro
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flashReq      <= 1'b0;
            flashOp       <= 3'h0;
            flashDataArea <= 1'b0;
            flashAddr     <= 20'h0_0000;
            flashWdata    <= 32'h0000_0000;
            flashByteEn   <= 4'h0;
        end else begin
            flashReq <= stateQ == CDFS_ST_ISSUE;
            if (stateQ == CDFS_ST_ISSUE) begin
                flashOp       <= cmdQ;
                flashDataArea <= modeDataQ || selQ;
                flashAddr     <= curAddrQ;
                if (modeDataQ || selQ) begin
                    flashWdata  <= {24'h00_0000, wbuf[7:0]};
                    flashByteEn <= `CDFS_BE_BYTE;
                end else begin
                    flashWdata  <= wbuf;
                    flashByteEn <= `CDFS_BE_WORD;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            failAccQ <= 1'b0;
        end else if (launchQ) begin
            failAccQ <= 1'b0;
        end else if (stateQ == CDFS_ST_WAIT && flashAck && flashFail) begin
            failAccQ <= 1'b1;
        end
    end

    // Sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            doneQ    <= 1'b0;
            failQ    <= 1'b0;
            illegalQ <= 1'b0;
        end else begin
            if (finish) begin
                doneQ <= 1'b1;
            end else if (wrLow && avs_address == `CDFS_IDX_STATUS
                         && avs_writedata[`CDFS_ST_DONE]) begin
                doneQ <= 1'b0;
            end
            if (finish && !badLaunch && (failAccQ || flashFail)) begin
                failQ <= 1'b1;
            end else if (wrLow && avs_address == `CDFS_IDX_STATUS
                         && avs_writedata[`CDFS_ST_FAIL]) begin
                failQ <= 1'b0;
            end
            if (badLaunch) begin
                illegalQ <= 1'b1;
            end else if (wrLow && avs_address == `CDFS_IDX_STATUS
                         && avs_writedata[`CDFS_ST_ILLEGAL]) begin
                illegalQ <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

//--- tb/cdfs_sequencer_props.sv
`timescale 1ns/1ps
`default_nettype none

module cdfs_props (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // Register bus
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // Flash port
    input wire logic        flashReq,
    input wire logic [2:0]  flashOp,
    input wire logic        flashDataArea,
    input wire logic [19:0] flashAddr,
    input wire logic [31:0] flashWdata,
    input wire logic [3:0]  flashByteEn,
    input wire logic        flashAck,
    input wire logic        flashFail
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rstn);

    a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("wait request low too long");
    a_req_pulse: assert property (flashReq |=> !flashReq)
        else $error("flash request longer than one cycle");
    a_op_legal: assert property (flashReq |-> flashOp inside {3'h1, 3'h2, 3'h3, 3'h4})
        else $error("flash request with undefined command");
    a_code_word: assert property (flashReq && flashOp == 3'h1 && !flashDataArea |-> flashByteEn == 4'hF)
        else $error("code write not a full word");
    a_data_byte: assert property (flashReq && flashOp == 3'h1 && flashDataArea |->
        flashByteEn == 4'h1 && flashWdata[31:8] == 24'h0)
        else $error("data write not a single byte");
    a_erase_block: assert property (flashReq && flashOp == 3'h4 |-> flashAddr[9:0] == 10'h0)
        else $error("erase address not on a block");
    a_hold_args: assert property (!flashReq |->
        $stable({flashOp, flashDataArea, flashAddr, flashWdata, flashByteEn}))
        else $error("flash arguments changed between requests");
    a_ptr_upper: assert property (avs_read && !avs_waitrequest &&
        (avs_address == 4'h1 || avs_address == 4'h5) |-> avs_readdata[31:4] == 28'h0)
        else $error("pointer upper bits not zero");
endmodule

bind cdfs_sequencer cdfs_props cdfs_props_i (
    .clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .flashReq(flashReq),
    .flashOp(flashOp), .flashDataArea(flashDataArea), .flashAddr(flashAddr),
    .flashWdata(flashWdata), .flashByteEn(flashByteEn), .flashAck(flashAck),
    .flashFail(flashFail)
);

`default_nettype wire

//--- tb/cdfs_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin testsRun++; if ((got) !== (ex)) begin nFail++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end

module cdfs_sequencer_tb;
    logic        clk, rstn, avs_read, avs_write, avs_waitrequest, failMode;
    logic        flashReq, flashDataArea, flashAck, flashFail;
    logic [3:0]  avs_address, avs_byteenable, flashByteEn;
    logic [2:0]  flashOp;
    logic [19:0] flashAddr;
    logic [31:0] avs_writedata, avs_readdata, flashWdata, r;
    logic [15:0] wh, wl;
    logic [59:0] expQ[$], capQ[$];
    int          seed = 48333, nFail = 0, testsRun = 0, ackCnt = 0;
    int          i, t, n, cmd, md, sel, st, en, a, step;
    // Each verify aims at a fresh random area and runs there once
    int          cmdT[12] = '{1, 1, 2, 2, 3, 3, 4, 4, 0, 5, 6, 7};

    cdfs_sequencer cdfs_sequencer_i (
        .clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .flashReq(flashReq),
        .flashOp(flashOp), .flashDataArea(flashDataArea), .flashAddr(flashAddr),
        .flashWdata(flashWdata), .flashByteEn(flashByteEn), .flashAck(flashAck),
        .flashFail(flashFail)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic endOfTest;
        if (nFail == 0 && testsRun > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic bus(input logic w, input logic [3:0] ad, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        avs_address   <= ad;
        avs_writedata <= d;
        avs_write     <= w;
        avs_read      <= !w;
        do begin
            @(posedge clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        r = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        if (k >= 50) begin
            nFail++;
            endOfTest();
        end
    endtask

    // Flash macro: records each unit and answers after 1 to 4 cycles
    always @(posedge clk) begin
        flashAck  <= 1'b0;
        flashFail <= 1'b0;
        if (flashReq === 1'b1) begin
            capQ.push_back({flashOp, flashDataArea, flashAddr, flashWdata, flashByteEn});
            ackCnt <= 1 + ({$random(seed)} % 4);
        end else if (ackCnt == 1) begin
            flashAck  <= 1'b1;
            flashFail <= failMode;
            ackCnt    <= 0;
        end else if (ackCnt > 1) begin
            ackCnt <= ackCnt - 1;
        end
    end

    initial begin
        rstn = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        failMode = 1'b0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        for (i = 0; i < 16; i++) begin
            bus(1'b0, i[3:0], 32'h0);
            `CHK("reset value", 32'h0, r)
        end
        for (i = 1; i < 16; i++) begin
            if (i == 7 || i == 8) continue;
            a = $random(seed);
            n = $random(seed);
            avs_byteenable <= n[3:0];
            // Only enabled lanes of implemented bits may change
            t = {n[1] ? 8'hFF : 8'h00, n[0] ? 8'hFF : 8'h00};
            t &= (i == 1 || i == 5) ? 32'hF : i < 7 ? 32'hFFFF : 0;
            bus(1'b1, i[3:0], a);
            bus(1'b0, i[3:0], 32'h0);
            `CHK("readback", a & t, r)
        end
        avs_byteenable <= 4'hF;
        // The block has no extra area; the user area is taken as selected
        for (t = 0; t < 12; t++) begin
            cmd = cmdT[t];
            md = t % 2;
            sel = md && (cmd == 2 || cmd == 3);
            failMode <= (t == 1);
            // Code flash addresses kept word aligned
            st = $random(seed) & (md ? 32'h7FFFF : 32'h7FFFC);
            n = $random(seed) & 3;
            step = cmd == 4 ? 32'h400 : md ? 1 : 4;
            en = cmd == 1 ? 0 : cmd == 4 ? (st | 32'h3FF) + n * step : st + n * step + step - 1;
            wh = $random(seed);
            wl = $random(seed);
            bus(1'b1, 4'h7, md);
            bus(1'b1, 4'h1, st >> 16);
            bus(1'b1, 4'h2, st & 32'hFFFF);
            bus(1'b1, 4'h3, wh);
            bus(1'b1, 4'h4, wl);
            bus(1'b1, 4'h5, en >> 16);
            bus(1'b1, 4'h6, en & 32'hFFFF);
            expQ.delete();
            capQ.delete();
            a = cmd == 4 ? st & 32'hFFC00 : st;
            if (cmd >= 1 && cmd <= 4) begin
                do begin
                    expQ.push_back({cmd[2:0], md[0] | sel[0], a[19:0],
                        md ? {24'h0, wl[7:0]} : {wh, wl}, md ? 4'h1 : 4'hF});
                    a += step;
                end while (cmd != 1 && a <= en);
            end
            bus(1'b1, 4'h0, 32'h80 | sel << 3 | cmd);
            // Must be dropped while the sequencer runs
            if (expQ.size() > 0) bus(1'b1, 4'h2, 32'hFFFF);
            n = 0;
            do begin
                bus(1'b0, 4'h8, 32'h0);
                n++;
            end while (r[1] !== 1'b1 && n < 300);
            if (r[1] !== 1'b1) begin
                nFail++;
                endOfTest();
            end
            `CHK("status", {expQ.size() == 0, failMode, 2'b10}, r[3:0])
            bus(1'b0, 4'h0, 32'h0);
            `CHK("control", sel << 3 | cmd, r)
            bus(1'b0, 4'h2, 32'h0);
            `CHK("start low", st & 32'hFFFF, r)
            `CHK("unit count", expQ.size(), capQ.size())
            for (i = 0; i < expQ.size() && i < capQ.size(); i++) begin
                if (cmd == 1) `CHK("write unit", expQ[i], capQ[i])
                else `CHK("range unit", expQ[i][59:36], capQ[i][59:36])
            end
            bus(1'b1, 4'h8, 32'hE);
        end
        endOfTest();
    end
endmodule

`default_nettype wire
